// >>> qdtw_pkg.sv
// constants shared by the two-wire dac update controller
package qdtw_pkg;
  // bus and data word widths
  localparam int NCH      = 4;
  localparam int CODE_W   = 12;
  localparam int WORD_W   = 16;
  localparam int SEL_W    = 2;
  // upper five bits of the target address, low two from straps
  localparam logic [4:0] ADDR_BASE = 5'h03;
  // data word field positions
  localparam int BIT_GAIN  = 15;
  localparam int BIT_BUF   = 14;
  localparam int BIT_CLR_N = 13;
  localparam int BIT_PD_N  = 12;
  localparam int CODE_MSB  = 11;
  // pointer byte field and reset value
  localparam int PTR_CH_LSB = 0;
  localparam logic [7:0] PTR_RST = 8'h01;
  // byte counting
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [1:0] WB_PTR = 2'h0;
  localparam logic [1:0] WB_HI  = 2'h1;
  localparam logic [1:0] WB_LO  = 2'h2;
  // power-up delay after leaving power-down
  localparam int CLK_NS     = 40;
  localparam int PWRUP5_NS  = 2500;
  localparam int PWRUP3_NS  = 5000;
  localparam logic [7:0] PWRUP5_CYC = 8'((PWRUP5_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PWRUP3_CYC = 8'((PWRUP3_NS + CLK_NS - 1) / CLK_NS);
  // link states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_RXB  = 7'h08,
    ST_RACK = 7'h10,
    ST_TXB  = 7'h20,
    ST_MACK = 7'h40
  } qdtw_state_t;
endpackage : qdtw_pkg

// >>> qdtw_bank_if.sv
// carrier between link logic and channel register bank
`timescale 1ns/10ps
`default_nettype none
interface qdtw_bank_if;
  import qdtw_pkg::*;
  logic                           wr_en;
  logic [NCH-1:0]                 wr_mask;
  logic [WORD_W-1:0]              wr_word;
  logic                           load_low;
  logic [SEL_W-1:0]               rd_sel;
  logic [WORD_W-1:0]              rd_word;
  logic [NCH-1:0][CODE_W-1:0]     out_code;
  logic [NCH-1:0]                 out_gain;
  logic [NCH-1:0]                 out_buf;
  modport link (
    output wr_en, wr_mask, wr_word, load_low, rd_sel,
    input  rd_word, out_code, out_gain, out_buf
  );
  modport bank (
    input  wr_en, wr_mask, wr_word, load_low, rd_sel,
    output rd_word, out_code, out_gain, out_buf
  );
endinterface : qdtw_bank_if
`default_nettype wire

// >>> qdtw_bank.sv
// input and output registers of the four channels
`timescale 1ns/10ps
`default_nettype none
module qdtw_bank (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // link side
  qdtw_bank_if.bank bus
);
  import qdtw_pkg::*;

  logic [NCH-1:0][WORD_W-1:0] in_reg;
  logic [NCH-1:0]             dirty;
  logic [WORD_W-1:0]          clr_word;

  ////////////////////////////////////////////////////////////////
  // clear bit low zeroes the code field of the written word
  assign clr_word = bus.wr_word[BIT_CLR_N] ? bus.wr_word :
                    (bus.wr_word & ~(WORD_W'({CODE_W{1'b1}}) << (CODE_MSB + 1 - CODE_W)));

  ////////////////////////////////////////////////////////////////
  // per-channel double buffer
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic wr_hit;
      logic upd;
      assign wr_hit = bus.wr_en & bus.wr_mask[g];
      assign upd = bus.load_low & dirty[g];
      always_ff @(posedge clock) begin
        if (rst) begin
          in_reg[g] <= '0;
        end else if (wr_hit) begin
          in_reg[g] <= clr_word;
        end
      end
      always_ff @(posedge clock) begin
        if (rst) begin
          dirty[g] <= 1'b0;
        end else begin
          dirty[g] <= wr_hit | (dirty[g] & ~upd);
        end
      end
      always_ff @(posedge clock) begin
        if (rst) begin
          bus.out_code[g] <= '0;
          bus.out_gain[g] <= 1'b0;
          bus.out_buf[g]  <= 1'b0;
        end else if (upd) begin
          bus.out_code[g] <= in_reg[g][CODE_MSB -: CODE_W];
          bus.out_gain[g] <= in_reg[g][BIT_GAIN];
          bus.out_buf[g]  <= in_reg[g][BIT_BUF];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // readback word of selected channel
  always_ff @(posedge clock) begin
    if (rst) begin
      bus.rd_word <= '0;
    end else begin
      bus.rd_word <= in_reg[bus.rd_sel];
    end
  end
endmodule : qdtw_bank
`default_nettype wire

// >>> qdtw_ctrl.sv
// two-wire target and update control of a quad dac
`timescale 1ns/10ps
`default_nettype none
module qdtw_ctrl #(
  parameter int N_CH = qdtw_pkg::NCH,
  parameter int CW   = qdtw_pkg::CODE_W
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // two-wire bus
  input  wire logic                      scl,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  // straps and control pins
  input  wire logic                      addr_select0,
  input  wire logic                      addr_select1,
  input  wire logic                      load_strobe_n,
  input  wire logic                      powerdown_ctrl_n,
  input  wire logic                      low_supply,
  // analog side
  output logic [qdtw_pkg::NCH-1:0][qdtw_pkg::CODE_W-1:0] dac_code,
  output logic [qdtw_pkg::NCH-1:0]       dac_gain,
  output logic [qdtw_pkg::NCH-1:0]       dac_buf,
  output logic                           dac_out_en,
  output logic                           powered_down
);
  import qdtw_pkg::*;

  localparam int NPIN = 7;

  // pin synchronisers
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_raw;
  logic            scl_prev;
  logic            sda_prev;
  wire             scl_s;
  wire             sda_s;
  wire             a0_s;
  wire             a1_s;
  wire             ld_n_s;
  wire             pd_n_s;
  wire             low_s;

  // bus event decode
  wire             scl_rise;
  wire             scl_fall;
  wire             start_det;
  wire             stop_det;
  wire [6:0]       own_addr;
  wire [7:0]       rx_byte;
  wire             addr_hit;
  wire             rx_done;

  // link state
  qdtw_state_t     state;
  qdtw_state_t     next_state;
  logic [3:0]      bitcnt;
  logic [3:0]      next_bitcnt;
  logic [7:0]      shreg;
  logic [7:0]      txsh;
  logic [7:0]      next_txsh;
  logic            rw;
  logic            next_rw;
  logic [1:0]      wcnt;
  logic [1:0]      next_wcnt;
  logic            tx_hi;
  logic            next_tx_hi;
  logic            mack_ok;
  logic            next_mack_ok;
  logic            oe;
  logic            next_oe;
  wire  [7:0]      tx_byte;

  // word assembly
  logic [7:0]      pointer;
  logic [7:0]      hi_byte;
  logic            pd_bit;
  wire             word_commit;
  logic [SEL_W-1:0] rd_sel;

  // power-up timing
  wire             active;
  wire  [7:0]      pwrup_lim;
  logic [7:0]      pwrup_cnt;

  qdtw_bank_if     bank_bus ();

  ////////////////////////////////////////////////////////////////
  // two flip-flop synchronisers for every pin
  assign pin_raw = {low_supply, powerdown_ctrl_n, load_strobe_n,
                    addr_select1, addr_select0, sda_in, scl};

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  assign scl_s  = pin_s2[0];
  assign sda_s  = pin_s2[1];
  assign a0_s   = pin_s2[2];
  assign a1_s   = pin_s2[3];
  assign ld_n_s = pin_s2[4];
  assign pd_n_s = pin_s2[5];
  assign low_s  = pin_s2[6];

  // previous levels for edge finding
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////
  // edges, start and stop conditions
  assign scl_rise  = scl_s & ~scl_prev;
  assign scl_fall  = ~scl_s & scl_prev;
  assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

  assign own_addr = {ADDR_BASE, a1_s, a0_s};
  assign addr_hit = (shreg[7:1] == own_addr);

  // byte complete on the eighth rising clock
  assign rx_byte = {shreg[6:0], sda_s};
  assign rx_done = (state == ST_RXB) & scl_rise & (bitcnt == BIT_LAST);

  // byte to send alternates high and low
  assign tx_byte = tx_hi ? bank_bus.rd_word[15:8] : bank_bus.rd_word[7:0];

  ////////////////////////////////////////////////////////////////
  // receive shifter
  always_ff @(posedge clock) begin
    if (rst) begin
      shreg <= '0;
    end else if (scl_rise) begin
      shreg <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////
  // link sequencing
  always_comb begin
    next_state   = state;
    next_bitcnt  = bitcnt;
    next_txsh    = txsh;
    next_rw      = rw;
    next_wcnt    = wcnt;
    next_tx_hi   = tx_hi;
    next_mack_ok = mack_ok;
    next_oe      = oe;
    if (start_det) begin
      next_state  = ST_ADDR;
      next_bitcnt = '0;
      next_oe     = 1'b0;
    end else if (stop_det) begin
      next_state = ST_IDLE;
      next_oe    = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == BITS_BYTE) begin
            next_bitcnt = '0;
            if (addr_hit) begin
              next_state = ST_AACK;
              next_oe    = 1'b1;
              next_rw    = shreg[0];
              next_tx_hi = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_state  = ST_TXB;
              next_oe     = ~tx_byte[7];
              next_txsh   = {tx_byte[6:0], 1'b0};
              next_bitcnt = 4'h1;
            end else begin
              next_state  = ST_RXB;
              next_oe     = 1'b0;
              next_wcnt   = WB_PTR;
              next_bitcnt = '0;
            end
          end
        end
        ST_RXB: begin
          if (scl_rise) begin
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scl_fall && bitcnt == BITS_BYTE) begin
            next_state  = ST_RACK;
            next_oe     = 1'b1;
            next_bitcnt = '0;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            next_state = ST_RXB;
            next_oe    = 1'b0;
            // further words go to the same pointer
            next_wcnt  = (wcnt == WB_HI) ? WB_LO : WB_HI;
          end
        end
        ST_TXB: begin
          if (scl_fall) begin
            if (bitcnt == BITS_BYTE) begin
              next_state  = ST_MACK;
              next_oe     = 1'b0;
              next_bitcnt = '0;
              next_tx_hi  = ~tx_hi;
            end else begin
              next_oe     = ~txsh[7];
              next_txsh   = {txsh[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            next_mack_ok = ~sda_s;
          end
          if (scl_fall) begin
            if (mack_ok) begin
              next_state  = ST_TXB;
              next_oe     = ~tx_byte[7];
              next_txsh   = {tx_byte[6:0], 1'b0};
              next_bitcnt = 4'h1;
            end else begin
              next_state = ST_IDLE;
              next_oe    = 1'b0;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_oe    = 1'b0;
        end
      endcase
    end
  end

  // link state registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state   <= ST_IDLE;
      bitcnt  <= '0;
      txsh    <= '0;
      rw      <= 1'b0;
      wcnt    <= WB_PTR;
      tx_hi   <= 1'b1;
      mack_ok <= 1'b0;
      oe      <= 1'b0;
    end else begin
      state   <= next_state;
      bitcnt  <= next_bitcnt;
      txsh    <= next_txsh;
      rw      <= next_rw;
      wcnt    <= next_wcnt;
      tx_hi   <= next_tx_hi;
      mack_ok <= next_mack_ok;
      oe      <= next_oe;
    end
  end

  // open-drain data line: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = oe;

  ////////////////////////////////////////////////////////////////
  // word complete on last data byte
  assign word_commit = rx_done & (wcnt == WB_LO);

  always_ff @(posedge clock) begin
    if (rst) begin
      pointer <= PTR_RST;
      hi_byte <= '0;
    end else if (rx_done) begin
      if (wcnt == WB_PTR) begin
        pointer <= rx_byte;
      end
      if (wcnt == WB_HI) begin
        hi_byte <= rx_byte;
      end
    end
  end

  // power bit taken from every written word
  always_ff @(posedge clock) begin
    if (rst) begin
      pd_bit <= 1'b1;
    end else if (word_commit) begin
      pd_bit <= hi_byte[BIT_PD_N - 8];
    end
  end

  always_comb begin
    rd_sel = '0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (pointer[PTR_CH_LSB + i]) begin
        rd_sel = SEL_W'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // channel bank hookup
  assign bank_bus.wr_en    = word_commit;
  assign bank_bus.wr_mask  = pointer[PTR_CH_LSB +: NCH];
  assign bank_bus.wr_word  = {hi_byte, rx_byte};
  assign bank_bus.load_low = ~ld_n_s;
  assign bank_bus.rd_sel   = rd_sel;

  qdtw_bank u_bank (
    .clock (clock),
    .rst   (rst),
    .bus   (bank_bus.bank)
  );

  assign dac_code = bank_bus.out_code;
  assign dac_gain = bank_bus.out_gain;
  assign dac_buf  = bank_bus.out_buf;

  ////////////////////////////////////////////////////////////////
  // powered only with pin high and bit one
  assign active    = pd_n_s & pd_bit;
  assign pwrup_lim = low_s ? PWRUP3_CYC : PWRUP5_CYC;

  always_ff @(posedge clock) begin
    if (rst) begin
      pwrup_cnt <= '0;
    end else if (!active) begin
      pwrup_cnt <= '0;
    end else if (pwrup_cnt < pwrup_lim) begin
      pwrup_cnt <= pwrup_cnt + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dac_out_en   <= 1'b0;
      powered_down <= 1'b1;
    end else begin
      dac_out_en   <= active & (pwrup_cnt >= pwrup_lim);
      powered_down <= ~active;
    end
  end
endmodule : qdtw_ctrl
`default_nettype wire

// >>> qdtw_ctrl_props.sv
// concurrent checks on the dac controller's top ports
`timescale 1ns/10ps
`default_nettype none
module qdtw_ctrl_props (
  // clock and reset
  input  wire logic                                        clock,
  input  wire logic                                        rst,
  // bus pins
  input  wire logic                                        scl,
  input  wire logic                                        sda_out,
  input  wire logic                                        sda_oe,
  // control pins
  input  wire logic                                        load_strobe_n,
  input  wire logic                                        powerdown_ctrl_n,
  input  wire logic                                        low_supply,
  // analog side
  input  wire logic [qdtw_pkg::NCH-1:0][qdtw_pkg::CODE_W-1:0] dac_code,
  input  wire logic [qdtw_pkg::NCH-1:0]                    dac_gain,
  input  wire logic [qdtw_pkg::NCH-1:0]                    dac_buf,
  input  wire logic                                        dac_out_en,
  input  wire logic                                        powered_down
);
  import qdtw_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // cycles since power-down ended, and recent strobe-low samples
  logic [7:0] wake_cnt;
  logic [5:0] ls_hist;
  always_ff @(posedge clock) begin
    if (rst) begin
      wake_cnt <= 8'h00;
      ls_hist  <= 6'h00;
    end else begin
      wake_cnt <= powered_down ? 8'h00 : wake_cnt + {7'h00, wake_cnt != 8'hff};
      ls_hist  <= {ls_hist[4:0], !load_strobe_n};
    end
  end
  // pin held low, strobe held high
  sequence s_pin_low;
    !powerdown_ctrl_n [*4];
  endsequence
  sequence s_strobe_high;
    load_strobe_n [*5];
  endsequence
  ////////////////////////////////////////
  a_pin_down: assert property (s_pin_low |=> powered_down)
    else $error("pin low did not power down");
  a_down_off: assert property (powered_down |=> !dac_out_en)
    else $error("outputs connected while powered down");
  a_wake_early: assert property ($rose(dac_out_en) |->
    wake_cnt >= (low_supply ? PWRUP3_CYC : PWRUP5_CYC) - 8'h01)
    else $error("outputs resumed too early");
  a_wake_late: assert property (
    wake_cnt == (low_supply ? PWRUP3_CYC : PWRUP5_CYC) + 8'h08 |->
    dac_out_en) else $error("outputs resumed too late");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_ack_slot: assert property ($changed(sda_oe) |-> !scl)
    else $error("data pin changed while bus clock high");
  a_latch_hold: assert property (s_strobe_high |=>
    $stable(dac_code) && $stable(dac_gain) && $stable(dac_buf))
    else $error("output registers moved with strobe high");
  a_update_cause: assert property ($changed({dac_code, dac_gain, dac_buf}) |->
    ls_hist != 6'h00) else $error("output registers moved without strobe low");
endmodule : qdtw_ctrl_props
bind qdtw_ctrl qdtw_ctrl_props u_props (.clock(clock), .rst(rst), .scl(scl),
  .sda_out(sda_out), .sda_oe(sda_oe), .load_strobe_n(load_strobe_n),
  .powerdown_ctrl_n(powerdown_ctrl_n), .low_supply(low_supply), .dac_code(dac_code),
  .dac_gain(dac_gain), .dac_buf(dac_buf), .dac_out_en(dac_out_en),
  .powered_down(powered_down));
`default_nettype wire

// >>> qdtw_bus_master.sv
// two-wire bus master model at the far side of the dac controller
`timescale 1ns/10ps
`default_nettype none
module qdtw_bus_master (
  // clock and bus
  input  wire logic       clock,
  input  wire logic       sda,
  output logic            scl,
  output logic            pull,
  // received bytes
  output logic [7:0]      rx,
  output logic            rx_stb
);
  ////////////////////////////////////////
  // idle bus: clock stands high, data left to the pull-up
  initial begin
    scl    = 1'b1;
    pull   = 1'b0;
    rx     = 8'h00;
    rx_stb = 1'b0;
  end
  // wait a number of system clocks
  task automatic q(input int n);
    repeat (n) @(posedge clock);
  endtask : q
  // one bit slot
  // data moves mid low phase, read at the end of the high phase
  task automatic bitx(input logic b, output logic r);
    q(2);
    pull <= !b;
    q(2);
    scl <= 1'b1;
    q(4);
    r = sda;
    scl <= 1'b0;
  endtask : bitx
  // start (0,1) or stop (1,0)
  // data changes while the clock stands high
  task automatic cond(input logic p0, input logic p1);
    q(2);
    pull <= p0;
    q(2);
    scl <= 1'b1;
    q(4);
    pull <= p1;
    q(4);
    scl <= p0;
  endtask : cond
  // byte out msb first, ack 0 means taken
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, ack);
  endtask : wbyte
  // byte in, then ack it or let the line go
  task automatic rbyte(input logic mack);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    rx <= d;
    rx_stb <= 1'b1;
    q(1);
    rx_stb <= 1'b0;
    bitx(!mack, r);
  endtask : rbyte
endmodule : qdtw_bus_master
`default_nettype wire

// >>> quad_dac_twowire_update_ctrl_tb.sv
// self-checking bench for the two-wire dac update controller
`timescale 1ns/10ps
`default_nettype none
module quad_dac_twowire_update_ctrl_tb;
  import qdtw_pkg::*;
  // pins, bus wires and outputs
  logic                       clock = 1'b0;
  logic                       rst = 1'b1;
  logic                       addr_select0 = 1'b0;
  logic                       addr_select1 = 1'b0;
  logic                       load_strobe_n = 1'b0;
  logic                       powerdown_ctrl_n = 1'b1;
  logic                       low_supply = 1'b0;
  wire logic                  scl, pull, sda_in, rx_stb;
  wire logic [7:0]            rx;
  logic                       sda_out, sda_oe, dac_out_en, powered_down, k;
  logic [NCH-1:0][CODE_W-1:0] dac_code;
  logic [NCH-1:0]             dac_gain, dac_buf;
  int                         failures = 0;
  int                         checks_done = 0;
  logic [31:0]                lfsr = 32'hc1f3;
  logic [7:0]                 exp_q[$];
  logic [11:0]                c1, c2, c3, c5;
  ////////////////////////////////////////
  // open-drain data wire with a pull-up
  assign sda_in = !(pull | (sda_oe & !sda_out));
  qdtw_ctrl u_dut (.clock(clock), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select0(addr_select0), .addr_select1(addr_select1),
    .load_strobe_n(load_strobe_n), .powerdown_ctrl_n(powerdown_ctrl_n),
    .low_supply(low_supply), .dac_code(dac_code), .dac_gain(dac_gain), .dac_buf(dac_buf),
    .dac_out_en(dac_out_en), .powered_down(powered_down));
  qdtw_bus_master u_mst (.clock(clock), .sda(sda_in), .scl(scl), .pull(pull), .rx(rx),
    .rx_stb(rx_stb));
  // 25 MHz clock
  initial forever #20 clock = ~clock;
  // random codes from a shift register
  function automatic logic [11:0] rnd12();
    lfsr = {1'b0, lfsr[31:1]} ^ (lfsr[0] ? 32'h80200003 : 32'h00000000);
    return lfsr[11:0];
  endfunction : rnd12
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // bus helpers: address byte, acked byte, write, read
  function automatic logic [7:0] adr(input logic rd);
    return {ADDR_BASE, addr_select1, addr_select0, rd};
  endfunction : adr
  task automatic send(input logic [7:0] b);
    u_mst.wbyte(b, k);
    check({15'h0000, k}, 16'h0000); // acked
  endtask : send
  task automatic wr(input logic [7:0] ptr, input logic [15:0] w);
    u_mst.cond(1'b0, 1'b1);
    send(adr(1'b0)); // address
    send(ptr); // pointer
    send(w[15:8]); // high byte
    send(w[7:0]); // low byte
    u_mst.cond(1'b1, 1'b0);
  endtask : wr
  task automatic rd(input logic pre, input logic [7:0] ptr, input int n, input logic [15:0] w);
    if (pre) begin
      u_mst.cond(1'b0, 1'b1);
      send(adr(1'b0)); // address
      send(ptr); // pointer
    end
    u_mst.cond(1'b0, 1'b1);
    send(adr(1'b1)); // read address
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(i[0] ? w[7:0] : w[15:8]);
      u_mst.rbyte(i < n - 1);
    end
    u_mst.cond(1'b1, 1'b0);
  endtask : rd
  task automatic wait_en(input int lim);
    int i;
    for (i = 0; i < lim && dac_out_en !== 1'b1; i++) @(posedge clock);
    if (i == lim) begin
      check({15'h0000, dac_out_en}, 16'h0001); // woke
      wrap_up();
    end
  endtask : wait_en
  // read bytes against the oldest note
  always @(posedge clock) begin
    if (rx_stb) check({8'h00, rx}, {8'h00, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hff});
  end
  ////////////////////////////////////////
  // main sequence
  initial begin
    @(posedge clock);
    addr_select0 <= lfsr[3];
    addr_select1 <= lfsr[7];
    repeat (19) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    c1 = rnd12();
    wr(8'h01, {4'hf, c1});
    check({4'h0, dac_code[0]}, {4'h0, c1}); // sync load
    check({14'h0000, dac_gain[0], dac_buf[0]}, 16'h0003); // selects
    wait_en(200);
    $display("test sync write done");
    load_strobe_n <= 1'b1;
    c2 = rnd12();
    wr(8'h0e, {4'h3, c2});
    check({4'h0, dac_code[1]}, 16'h0000); // held
    load_strobe_n <= 1'b0;
    repeat (8) @(posedge clock);
    for (int i = 1; i < NCH; i++) check({4'h0, dac_code[i]}, {4'h0, c2}); // loaded
    check({4'h0, dac_code[0]}, {4'h0, c1}); // untouched
    $display("test async load done");
    c3 = rnd12();
    wr(8'h04, {4'h9, c3});
    check({4'h0, dac_code[2]}, 16'h0000); // cleared
    rd(1'b1, 8'h04, 4, 16'h9000); // repeat
    rd(1'b0, 8'h00, 2, 16'h9000); // stored pointer
    rd(1'b1, 8'h02, 2, {4'h3, c2}); // channel b
    check(16'(exp_q.size()), 16'h0000); // all read
    $display("test readback done");
    u_mst.cond(1'b0, 1'b1);
    u_mst.wbyte(adr(1'b0) ^ 8'h02, k);
    check({15'h0000, k}, 16'h0001); // not ours
    u_mst.cond(1'b1, 1'b0);
    $display("test address done");
    c5 = rnd12();
    wr(8'h08, {4'h2, c5});
    repeat (8) @(posedge clock);
    check({14'h0000, powered_down, dac_out_en}, 16'h0002); // down
    check({4'h0, dac_code[3]}, {4'h0, c5}); // written
    powerdown_ctrl_n <= 1'b0;
    low_supply <= 1'b1;
    wr(8'h08, {4'h3, c5});
    repeat (8) @(posedge clock);
    check({15'h0000, powered_down}, 16'h0001); // pin low
    powerdown_ctrl_n <= 1'b1;
    wait_en(300);
    check({14'h0000, powered_down, dac_out_en}, 16'h0001); // normal again
    check({4'h0, dac_code[0]}, {4'h0, c1}); // kept
    $display("test power-down done");
    wrap_up();
  end
endmodule : quad_dac_twowire_update_ctrl_tb
`default_nettype wire
